// file: config_word_protection_ident.v
// Configuration word decoder with program/data memory protection and ID space.
// Assumes word values come from nonvolatile storage and stand at reset release.
`timescale 1ns/1ps
`include "cfgprot_consts.vh"

// Function
// - Enable bit allows low-voltage programming entry
// - Refuse clearing enable after low-voltage entry
// - Debug bit gives serial pins to debugger
// - Brown-out threshold select chooses trip level
// - Stack fault resets when enabled
// - Clock multiplier follows its enable bit
// - Unimplemented word bits read as one
// - Self-write protect field blocks low regions
// - Program protection blocks external access, reads zero
// - CPU reads always, writes gated by field
// - Data protection blocks external EEPROM access
// - CPU EEPROM access never blocked
// - Program and data protection independent
// - Four user ID locations, read/write
// - Identification word: part and step codes
// - Identification word writes ignored
// - Protection bits from first word 8, 7
// - Overflow past sixteen, underflow on a pop when empty
module config_word_protection_ident
#(
	parameter [8:0] PART_ID   = 9'h0a5,   // Value arbitrary
	parameter [4:0] STEP_CODE = 5'h01,    // Value arbitrary
	parameter       STACK_DEPTH = 16
)
(
	input  wire        CLK,
	input  wire        RST_N,
	input  wire [13:0] NV_CW1,
	input  wire [13:0] NV_CW2,
	input  wire        LV_ENTRY,
	input  wire        EXT_RESET_PIN_HV,
	input  wire [15:0] ADDR,
	input  wire [13:0] WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [13:0] RDATA,
	input  wire        EXT_PM_RD,
	input  wire        EXT_PM_WR,
	input  wire [10:0] EXT_PM_ADDR,
	input  wire [13:0] PM_DATA_IN,
	output reg  [13:0] EXT_PM_RDATA,
	output reg         PM_WR_EN,
	output reg         EXT_EE_RD_EN,
	output reg         EXT_EE_WR_EN,
	input  wire        EXT_EE_RD,
	input  wire        EXT_EE_WR,
	input  wire        CPU_PM_WR,
	input  wire [10:0] CPU_PM_ADDR,
	output reg         CPU_PM_WR_EN,
	input  wire        CPU_EE_RD,
	input  wire        CPU_EE_WR,
	output reg         CPU_EE_RD_EN,
	output reg         CPU_EE_WR_EN,
	input  wire        STACK_PUSH,
	input  wire        STACK_POP,
	output reg         STACK_FAULT_RESET,
	output reg         STACK_OVERFLOW_FLAG,
	output reg         STACK_UNDERFLOW_FLAG,
	output reg         PROG_ENTRY_ALLOWED,
	output reg         DEBUG_PINS_DEDICATED,
	output reg         BROWNOUT_LOW_TRIP,
	output reg         CLOCK_MULT_EN,
	output reg         LV_CLEAR_REFUSED
);

	// ****************************************************************
	// Captured configuration
	// ****************************************************************
	reg [13:0] cw1_q;
	reg [13:0] cw2_q;
	reg        loaded_q;
	reg [13:0] uid_q [0:3];
	reg        hv_s1_q;
	reg        hv_s2_q;
	reg        pm_protect_n;
	reg        ee_protect_n;
	reg        lv_prog_en;
	wire       cpu_allow;
	wire       ext_allow;
	wire       ovf_p;
	wire       unf_p;
	integer    i;

	// Field readback with unimplemented bits forced high
	function [13:0] cw2_view;
		input [13:0] w;
		begin
			cw2_view = w | `CW2_ONES_MASK;
		end
	endfunction

	// User ID window check, shared by the write and read decoders
	function in_uid_space;
		input [15:0] a;
		begin
			in_uid_space = (a >= `UID_BASE) && (a <= `UID_LAST);
		end
	endfunction

	// Words are captured once after reset release; the clocked capture avoids
	// loading port values under asynchronous reset
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cw1_q    <= `CW_ERASED;
			cw2_q    <= `CW_ERASED;
			loaded_q <= 1'b0;
		end
		else if (!loaded_q)
		begin
			cw1_q    <= NV_CW1;
			cw2_q    <= cw2_view(NV_CW2);
			loaded_q <= 1'b1;
		end
	end

	// High-voltage level on the reset pin is asynchronous
	// Only the second stage feeds logic; the first may still be settling
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			hv_s1_q <= 1'b0;
			hv_s2_q <= 1'b0;
		end
		else
		begin
			hv_s1_q <= EXT_RESET_PIN_HV;
			hv_s2_q <= hv_s1_q;
		end
	end

	// Decoded protection bits, each evaluated on its own
	always @*
	begin
		pm_protect_n = cw1_q[`PROG_PROT_BIT];
		ee_protect_n = cw1_q[`DATA_PROT_BIT];
		lv_prog_en   = cw2_q[`LV_PROG_BIT];
	end

	// ****************************************************************
	// Helper blocks
	// ****************************************************************
	// CPU self-writes are limited by the captured protect field
	self_write_guard u_cpu_guard
	(
		.protect_field (cw2_q[`SWP_HI:`SWP_LO]),
		.addr          (CPU_PM_ADDR),
		.allowed       (cpu_allow)
	);

	// External writes are not bound by the self-write field, so this guard
	// stays wide open; it keeps one place to add a region limit later
	self_write_guard u_ext_guard
	(
		.protect_field (2'b11),
		.addr          (EXT_PM_ADDR),
		.allowed       (ext_allow)
	);

	// Depth counter sees every push and pop; the enable is applied below
	stack_fault_detect #(.DEPTH(STACK_DEPTH)) u_stack
	(
		.clk       (CLK),
		.rst_n     (RST_N),
		.push      (STACK_PUSH),
		.pop       (STACK_POP),
		.overflow  (ovf_p),
		.underflow (unf_p)
	);

	// ****************************************************************
	// Decoded control outputs
	// ****************************************************************
	// Debug, brown-out and clock levels follow the captured words and cannot move before next reset; entry permission tracks the pins
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			PROG_ENTRY_ALLOWED   <= 1'b0;
			DEBUG_PINS_DEDICATED <= 1'b0;
			BROWNOUT_LOW_TRIP    <= 1'b1;
			CLOCK_MULT_EN        <= 1'b0;
		end
		else
		begin
			// Low-voltage entry needs the enable; high voltage always works
			PROG_ENTRY_ALLOWED   <= (lv_prog_en && LV_ENTRY) || hv_s2_q;
			DEBUG_PINS_DEDICATED <= !cw2_q[`DBG_BIT];
			BROWNOUT_LOW_TRIP    <= cw2_q[`BROWNOUT_SEL_BIT];
			CLOCK_MULT_EN        <= cw2_q[`PLL_BIT] && loaded_q;
		end
	end

	// ****************************************************************
	// Stack fault reset and flags
	// ****************************************************************
	// Flags are sticky until device reset, which clears them here
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			STACK_FAULT_RESET    <= 1'b0;
			STACK_OVERFLOW_FLAG  <= 1'b0;
			STACK_UNDERFLOW_FLAG <= 1'b0;
		end
		else
		begin
			// One-cycle request; the reset controller is expected to stretch it
			STACK_FAULT_RESET <= cw2_q[`STV_BIT] && (ovf_p || unf_p);
			if (cw2_q[`STV_BIT] && ovf_p)
				STACK_OVERFLOW_FLAG <= 1'b1;
			if (cw2_q[`STV_BIT] && unf_p)
				STACK_UNDERFLOW_FLAG <= 1'b1;
		end
	end

	// ****************************************************************
	// Memory access gating
	// ****************************************************************
	// Enables are registered, so each answer comes one edge after its request
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			EXT_PM_RDATA <= 14'h0000;
			PM_WR_EN     <= 1'b0;
			EXT_EE_RD_EN <= 1'b0;
			EXT_EE_WR_EN <= 1'b0;
			CPU_PM_WR_EN <= 1'b0;
			CPU_EE_RD_EN <= 1'b0;
			CPU_EE_WR_EN <= 1'b0;
		end
		else
		begin
			// Protected program memory reads back as all zeros
			EXT_PM_RDATA <= (EXT_PM_RD && pm_protect_n) ? PM_DATA_IN : 14'h0000;
			PM_WR_EN     <= EXT_PM_WR && pm_protect_n && ext_allow;
			EXT_EE_RD_EN <= EXT_EE_RD && ee_protect_n;
			EXT_EE_WR_EN <= EXT_EE_WR && ee_protect_n;
			// CPU path ignores code protection; only the field limits writes
			CPU_PM_WR_EN <= CPU_PM_WR && cpu_allow;
			CPU_EE_RD_EN <= CPU_EE_RD;
			CPU_EE_WR_EN <= CPU_EE_WR;
		end
	end

	// ****************************************************************
	// Configuration space register port
	// ****************************************************************
	// Reads return one cycle after the strobe; unmapped addresses read zero
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			RDATA            <= 14'h0000;
			LV_CLEAR_REFUSED <= 1'b0;
			for (i = 0; i < 4; i = i + 1)
				uid_q[i] <= `CW_ERASED;
		end
		else
		begin
			LV_CLEAR_REFUSED <= 1'b0;
			if (WR)
			begin
				if (in_uid_space(ADDR))
					uid_q[ADDR[1:0]] <= WDATA;
				else if (ADDR == `CW2_ADDR)
				begin
					// Configuration is held until reset; only the refusal is reported
					LV_CLEAR_REFUSED <= LV_ENTRY && !WDATA[`LV_PROG_BIT];
				end
				// Identification word address falls through: write dropped
			end
			// Read data stand one cycle only, so a stale word is never seen twice
			if (RD)
			begin
				if (in_uid_space(ADDR))
					RDATA <= uid_q[ADDR[1:0]];
				else if (ADDR == `PARTID_ADDR)
					RDATA <= {PART_ID, STEP_CODE};
				else if (ADDR == `CW1_ADDR)
					RDATA <= cw1_q;
				else if (ADDR == `CW2_ADDR)
					RDATA <= cw2_view(cw2_q);
				else
					RDATA <= 14'h0000;
			end
			else
				RDATA <= 14'h0000;
		end
	end

endmodule

// file: cfgprot_consts.vh
// Constants for the configuration word decoder and memory protection block.
// Assumes 14-bit configuration words and a 16-bit configuration-space address.
`ifndef CFGPROT_CONSTS_VH
`define CFGPROT_CONSTS_VH

// Second configuration word field positions
`define LV_PROG_BIT      13
`define DBG_BIT          12
`define BROWNOUT_SEL_BIT 10
`define STV_BIT          9
`define PLL_BIT          8
`define RSVD_BIT         4
`define SWP_HI           1
`define SWP_LO           0
// Mask of bits that always read as one (11, 7-5, 4, 3-2)
`define CW2_ONES_MASK    14'h08fc
// First configuration word protection bits
`define DATA_PROT_BIT    8
`define PROG_PROT_BIT    7
// Reset value of an erased configuration word
`define CW_ERASED        14'h3fff
// Self-write protection limits
`define SWP_LIM_10       11'h1ff
`define SWP_LIM_01       11'h3ff
`define SWP_LIM_00       11'h7ff
// Configuration space addresses
`define UID_BASE         16'h8000
`define UID_LAST         16'h8003
`define PARTID_ADDR      16'h8006
`define CW1_ADDR         16'h8007
`define CW2_ADDR         16'h8008
// Identification word layout
`define PART_HI          13
`define PART_LO          5
`define STEP_HI          4
`define STEP_LO          0

`endif

// file: self_write_guard.v
// Self-write address guard: decides if a program memory self-write may proceed.
// Assumes an 11-bit program word address and a registered protect field.
`timescale 1ns/1ps
`include "cfgprot_consts.vh"

module self_write_guard
(
	input  wire [1:0]  protect_field,
	input  wire [10:0] addr,
	output reg         allowed
);

	// Blocked region starts at zero and ends at a limit picked by the field
	always @*
	begin
		case (protect_field)
			2'b11:   allowed = 1'b1;
			2'b10:   allowed = (addr > `SWP_LIM_10);
			2'b01:   allowed = (addr > `SWP_LIM_01);
			2'b00:   allowed = 1'b0;
			default: allowed = 1'b0;
		endcase
	end

endmodule

// file: stack_fault_detect.v
// Return-stack fault detector: flags overflow and underflow from the depth count.
// Assumes push and pop strobes come from CPU logic on the same clock.
`timescale 1ns/1ps

module stack_fault_detect
#(
	parameter DEPTH = 16
)
(
	input  wire clk,
	input  wire rst_n,
	input  wire push,
	input  wire pop,
	output reg  overflow,
	output reg  underflow
);

	reg [4:0] level_q;

	// Pulses for one cycle when a push finds the stack full or a pop finds it empty
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			level_q   <= 5'h00;
			overflow  <= 1'b0;
			underflow <= 1'b0;
		end
		else
		begin
			overflow  <= push && !pop && (level_q == DEPTH[4:0]);
			underflow <= pop && !push && (level_q == 5'h00);
			if (push && !pop && level_q != DEPTH[4:0])
				level_q <= level_q + 5'h01;
			else if (pop && !push && level_q != 5'h00)
				level_q <= level_q - 5'h01;
		end
	end

endmodule

// file: prog_tool.sv
// Programming tool model: supplies the stored words and program memory data.
// Assumes the bench sets the word values only while the block is in reset.
`timescale 1ns/1ps
module prog_tool
(
	input  wire [13:0] cw1_set,
	input  wire [13:0] cw2_set,
	input  wire [10:0] EXT_PM_ADDR,
	output wire [13:0] NV_CW1,
	output wire [13:0] NV_CW2,
	output wire [13:0] PM_DATA_IN
);
	// Tool always programs the reserved bit high; debug bit passes as commanded
	assign NV_CW2 = cw2_set | 14'h0010;
	assign NV_CW1 = cw1_set;
	// Data tied to address, so a stale or shifted word cannot pass
	assign PM_DATA_IN = {3'h5, EXT_PM_ADDR};
endmodule

// file: cfg_prot_sva.sv
// Checker for the configuration word decoder and protection gates.
// Assumes word inputs stay fixed while out of reset.
`timescale 1ns/1ps
module cfg_prot_sva
(
	input wire        CLK,
	input wire        RST_N,
	input wire [13:0] NV_CW1,
	input wire [13:0] NV_CW2,
	input wire        EXT_PM_RD,
	input wire        EXT_PM_WR,
	input wire [13:0] PM_DATA_IN,
	input wire [13:0] EXT_PM_RDATA,
	input wire        PM_WR_EN,
	input wire        EXT_EE_RD,
	input wire        EXT_EE_RD_EN,
	input wire        CPU_PM_WR,
	input wire [10:0] CPU_PM_ADDR,
	input wire        CPU_PM_WR_EN,
	input wire        CPU_EE_WR,
	input wire        CPU_EE_WR_EN,
	input wire        STACK_FAULT_RESET,
	input wire        STACK_OVERFLOW_FLAG,
	input wire        DEBUG_PINS_DEDICATED,
	input wire        BROWNOUT_LOW_TRIP,
	input wire        CLOCK_MULT_EN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Self-write permission worked out from the field and address
	wire [1:0] wf = NV_CW2[1:0];
	wire allow = (wf == 2'h3) | (wf == 2'h2 & CPU_PM_ADDR > 11'h1ff) | (wf == 2'h1 & CPU_PM_ADDR > 11'h3ff);
	property p_pm_zero; EXT_PM_RD && !NV_CW1[7] |=> EXT_PM_RDATA == 14'h0; endproperty
	a_pm_zero: assert property (p_pm_zero) else $error("protected read not zero");
	property p_pm_pass; EXT_PM_RD && NV_CW1[7] |=> EXT_PM_RDATA == $past(PM_DATA_IN); endproperty
	a_pm_pass: assert property (p_pm_pass) else $error("open read lost data");
	property p_pm_wr; EXT_PM_WR |=> PM_WR_EN == $past(NV_CW1[7]); endproperty
	a_pm_wr: assert property (p_pm_wr) else $error("external write gate wrong");
	property p_ee; EXT_EE_RD |=> EXT_EE_RD_EN == $past(NV_CW1[8]); endproperty
	a_ee: assert property (p_ee) else $error("eeprom read gate wrong");
	property p_cpu_ee; CPU_EE_WR |=> CPU_EE_WR_EN; endproperty
	a_cpu_ee: assert property (p_cpu_ee) else $error("cpu eeprom write blocked");
	property p_cpu_pm; CPU_PM_WR |=> CPU_PM_WR_EN == $past(allow); endproperty
	a_cpu_pm: assert property (p_cpu_pm) else $error("self-write gate wrong");
	property p_lvl; $past(RST_N, 2) |-> CLOCK_MULT_EN == NV_CW2[8] &&
		BROWNOUT_LOW_TRIP == NV_CW2[10] && DEBUG_PINS_DEDICATED == !NV_CW2[12]; endproperty
	a_lvl: assert property (p_lvl) else $error("decoded level wrong");
	property p_ovf; STACK_OVERFLOW_FLAG |=> STACK_OVERFLOW_FLAG; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag dropped");
	property p_stv; STACK_FAULT_RESET |-> NV_CW2[9]; endproperty
	a_stv: assert property (p_stv) else $error("stack reset while disabled");
	c_ovf: cover property (STACK_OVERFLOW_FLAG);
	c_prot: cover property (EXT_PM_RD && !NV_CW1[7]);
	c_wblk: cover property (CPU_PM_WR && !allow);
endmodule
bind config_word_protection_ident cfg_prot_sva u_cfg_prot_sva (.*);

// file: tb.sv
// Testbench: scenario tasks over register port, gates and stack detector.
// Assumes the tool model supplies the words and program memory data.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	localparam [8:0] PID = 9'h0c3; // Value arbitrary
	localparam [4:0] SID = 5'h02;  // Value arbitrary
	reg CLK, RST_N, LV_ENTRY, EXT_RESET_PIN_HV, WR, RD, EXT_PM_RD, EXT_PM_WR, EXT_EE_RD;
	reg EXT_EE_WR, CPU_PM_WR, CPU_EE_RD, CPU_EE_WR, STACK_PUSH, STACK_POP;
	reg  [15:0] ADDR;
	reg  [13:0] WDATA, cw1_set, cw2_set;
	reg  [10:0] EXT_PM_ADDR, CPU_PM_ADDR;
	wire [13:0] NV_CW1, NV_CW2, PM_DATA_IN, RDATA, EXT_PM_RDATA;
	wire PM_WR_EN, EXT_EE_RD_EN, EXT_EE_WR_EN, CPU_PM_WR_EN, CPU_EE_RD_EN, CPU_EE_WR_EN;
	wire STACK_FAULT_RESET, STACK_OVERFLOW_FLAG, STACK_UNDERFLOW_FLAG, PROG_ENTRY_ALLOWED;
	wire DEBUG_PINS_DEDICATED, BROWNOUT_LOW_TRIP, CLOCK_MULT_EN, LV_CLEAR_REFUSED;
	int n_errors = 0;
	int num_checks = 0;
	config_word_protection_ident #(.PART_ID(PID), .STEP_CODE(SID)) u_config_word_protection_ident (.*);
	prog_tool u_prog_tool (.*);
	// ****************************************
	// Clock, shared tasks
	// ****************************************
	initial
	begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	task print_verdict;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Words change only inside reset, since they are captured at release
	task do_reset(input [13:0] c1, input [13:0] c2);
		@(posedge CLK);
		{RST_N, LV_ENTRY, EXT_RESET_PIN_HV} <= 3'h0;
		cw1_set <= c1;
		cw2_set <= c2;
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (2) @(posedge CLK);
		#1;
	endtask
	task wr(input [15:0] a, input [13:0] d);
		@(posedge CLK);
		{ADDR, WDATA, WR} <= {a, d, 1'b1};
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task rd(input [15:0] a, input [13:0] e);
		@(posedge CLK);
		{ADDR, RD} <= {a, 1'b1};
		@(posedge CLK);
		RD <= 1'b0;
		#1 `CHK(RDATA, e)
	endtask
	// One-cycle strobes on the gated request inputs, answer seen one edge later
	task req(input [6:0] s, input [10:0] a);
		@(posedge CLK);
		{EXT_PM_RD, EXT_PM_WR, EXT_EE_RD, EXT_EE_WR, CPU_PM_WR, CPU_EE_RD, CPU_EE_WR} <= s;
		{EXT_PM_ADDR, CPU_PM_ADDR} <= {a, a};
		@(posedge CLK);
		{EXT_PM_RD, EXT_PM_WR, EXT_EE_RD, EXT_EE_WR, CPU_PM_WR, CPU_EE_RD, CPU_EE_WR} <= 7'h0;
		#1;
	endtask
	// Fault reset is a short pulse, so it is caught over a window
	task fault_watch(output reg s);
		s = 1'b0;
		repeat (6)
		begin
			@(posedge CLK);
			#1 s = s | STACK_FAULT_RESET;
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_regs;
		do_reset(14'h3fff, 14'h3503);
		rd(16'h8008, 14'h3dff);
		rd(16'h8006, {PID, SID});
		wr(16'h8006, 14'h0000);
		rd(16'h8006, {PID, SID});
		wr(16'h8003, 14'h1234);
		wr(16'h9000, 14'h0555);
		rd(16'h8003, 14'h1234);
		`CHK({DEBUG_PINS_DEDICATED, BROWNOUT_LOW_TRIP, CLOCK_MULT_EN}, 3'h3)
	endtask
	task t_prot;
		do_reset(14'h3eff, 14'h0003);
		`CHK({DEBUG_PINS_DEDICATED, BROWNOUT_LOW_TRIP, CLOCK_MULT_EN}, 3'h4)
		req(7'h7f, 11'h123);
		`CHK(EXT_PM_RDATA, {3'h5, 11'h123})
		`CHK({PM_WR_EN, EXT_EE_RD_EN, EXT_EE_WR_EN, CPU_EE_RD_EN, CPU_EE_WR_EN}, 5'h13)
		@(posedge CLK);
		LV_ENTRY <= 1'b1;
		repeat (4) @(posedge CLK);
		#1 `CHK(PROG_ENTRY_ALLOWED, 1'b0)
		@(posedge CLK);
		EXT_RESET_PIN_HV <= 1'b1;
		repeat (4) @(posedge CLK);
		#1 `CHK(PROG_ENTRY_ALLOWED, 1'b1)
		do_reset(14'h3f7f, 14'h3fff);
		req(7'h7f, 11'h123);
		`CHK({EXT_PM_RDATA, PM_WR_EN, EXT_EE_RD_EN, EXT_EE_WR_EN}, 17'h3)
		rd(16'h8007, 14'h3f7f);
	endtask
	task t_wrt;
		logic [10:0] al [4] = '{11'h1ff, 11'h200, 11'h3ff, 11'h400};
		reg ex;
		for (int f = 0; f < 4; f++)
		begin
			do_reset(14'h3fff, {12'hfff, f[1:0]});
			for (int i = 0; i < 4; i++)
			begin
				req(7'h04, al[i]);
				ex = (f == 3) || (f == 2 && al[i] > 11'h1ff) || (f == 1 && al[i] > 11'h3ff);
				`CHK(CPU_PM_WR_EN, ex)
			end
		end
	endtask
	task t_stack;
		reg seen;
		do_reset(14'h3fff, 14'h3fff);
		@(posedge CLK);
		STACK_PUSH <= 1'b1;
		repeat (17) @(posedge CLK);
		STACK_PUSH <= 1'b0;
		fault_watch(seen);
		`CHK({seen, STACK_OVERFLOW_FLAG, STACK_UNDERFLOW_FLAG}, 3'h6)
		// Underflow with the fault reset enabled, then with it disabled
		for (int en = 1; en >= 0; en--)
		begin
			do_reset(14'h3fff, en ? 14'h3fff : 14'h3dff);
			@(posedge CLK);
			STACK_POP <= 1'b1;
			@(posedge CLK);
			STACK_POP <= 1'b0;
			fault_watch(seen);
			`CHK({seen, STACK_OVERFLOW_FLAG, STACK_UNDERFLOW_FLAG}, en ? 3'h5 : 3'h0)
		end
	endtask
	task t_lv_clear;
		do_reset(14'h3fff, 14'h3fff);
		@(posedge CLK);
		LV_ENTRY <= 1'b1;
		wr(16'h8008, 14'h1fff);
		#1 `CHK(LV_CLEAR_REFUSED, 1'b1)
		rd(16'h8008, 14'h3fff);
		`CHK(PROG_ENTRY_ALLOWED, 1'b1)
		wr(16'h8008, 14'h3fff);
		#1 `CHK(LV_CLEAR_REFUSED, 1'b0)
	endtask
	// Every input gets a value at time zero
	initial
	begin
		{RST_N, LV_ENTRY, EXT_RESET_PIN_HV, WR, RD, EXT_PM_RD, EXT_PM_WR, EXT_EE_RD} = 8'h0;
		{EXT_EE_WR, CPU_PM_WR, CPU_EE_RD, CPU_EE_WR, STACK_PUSH, STACK_POP, ADDR, WDATA} = 36'h0;
		{EXT_PM_ADDR, CPU_PM_ADDR, cw1_set, cw2_set} = {22'h0, 14'h3fff, 14'h3fff};
		t_regs;
		t_prot;
		t_wrt;
		t_stack;
		t_lv_clear;
		print_verdict;
	end
	// Bound on the whole run
	initial
	begin
		repeat (5000) @(posedge CLK);
		n_errors++;
		print_verdict;
	end
endmodule
